// file: snv_regs.svh
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH

// opcodes
`define SNV_OP_STATUS_STORE 8'h01
`define SNV_OP_PROGRAM      8'h02
`define SNV_OP_READ         8'h03
`define SNV_OP_LATCH_CLEAR  8'h04
`define SNV_OP_STATUS_FETCH 8'h05
`define SNV_OP_LATCH_SET    8'h06
`define SNV_OP_FAST_FETCH   8'h0B
`define SNV_OP_PAGE_ERASE   8'h42
`define SNV_OP_CHIP_ERASE_A 8'h60
`define SNV_OP_CHIP_ERASE_B 8'hC7
`define SNV_OP_POWER_DOWN   8'hB9
`define SNV_OP_DEEP_SLEEP   8'h79
`define SNV_OP_WAKE         8'hAB
`define SNV_OP_NONE         8'h00

// status field positions
`define SNV_SR_BUSY      0
`define SNV_SR_LATCH     1
`define SNV_SR_GUARD_LO  2
`define SNV_SR_GUARD_HI  3
`define SNV_SR_ZERO      4
`define SNV_SR_LOW_STBY  5
`define SNV_SR_AUTO_SLP  6
`define SNV_SR_LOCK      7
`define SNV_SR_NV_MASK   8'hEC
`define SNV_SR_RESET     8'h00

// guarded regions and sizes
`define SNV_GUARD_QTR    14'h3000
`define SNV_GUARD_HALF   14'h2000
`define SNV_ARRAY_TOP    14'h3FFF
`define SNV_PAGE_BYTES   8'h80
`define SNV_MIN_PROGRAM  8'h04
`define SNV_MIN_ERASE    8'h03
`define SNV_MIN_STORE    8'h02

`endif

// file: snv_pkg.sv
package snv_pkg;

    typedef enum logic [6:0] {
        PH_IDLE  = 7'h01,
        PH_OPC   = 7'h02,
        PH_ADDR  = 7'h04,
        PH_DUMMY = 7'h08,
        PH_WDATA = 7'h10,
        PH_RDATA = 7'h20,
        PH_SKIP  = 7'h40
    } snv_phase_type;

    typedef enum logic [2:0] {
        AOP_NONE       = 3'h0,
        AOP_PROGRAM    = 3'h1,
        AOP_PAGE_ERASE = 3'h2,
        AOP_CHIP_ERASE = 3'h3,
        AOP_STATUS     = 3'h4
    } snv_aop_type;

    // block guard decode
    function automatic logic snv_guarded(input logic [1:0] bg, input logic [13:0] a);
        logic r;
        r = 1'b0;
        unique case (bg)
            2'h0: r = 1'b0;
            2'h1: r = (a >= 14'h3000);
            2'h2: r = (a >= 14'h2000);
            2'h3: r = 1'b1;
        endcase
        return r;
    endfunction

endpackage

// file: snv_link_if.sv
`timescale 1ns/10ps
`default_nettype none

interface snv_link_if;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic cs_low;
    logic serial_in_pin;
    logic wp_n;

    modport src (output sck_rise, sck_fall, cs_rise, cs_fall, cs_low, serial_in_pin, wp_n);
    modport dst (input sck_rise, sck_fall, cs_rise, cs_fall, cs_low, serial_in_pin, wp_n);
endinterface

`default_nettype wire

// file: snv_link_sync.sv
`timescale 1ns/10ps
`default_nettype none

module snv_link_sync
    import snv_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // pins
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_sdi,
    input  wire logic i_wp_n,
    // sampled link
    snv_link_if.src   lk
);

    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic       sck_p;
        logic       cs_n_p;
    } snv_sync_type;

    snv_sync_type q;
    snv_sync_type d;

    always_comb
    begin
        d        = q;
        d.s1     = {i_wp_n, i_sdi, i_cs_n, i_sck};
        d.s2     = q.s1;
        d.sck_p  = q.s2[0];
        d.cs_n_p = q.s2[1];
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            q <= '{s1: 4'hF, s2: 4'hF, sck_p: 1'b1, cs_n_p: 1'b1};
        else
            q <= d;
    end

    // edges of the sampled clock and select, whatever the clock's idle level
    assign lk.sck_rise = q.s2[0] & ~q.sck_p;
    assign lk.sck_fall = ~q.s2[0] & q.sck_p;
    assign lk.cs_fall  = ~q.s2[1] & q.cs_n_p;
    assign lk.cs_rise  = q.s2[1] & ~q.cs_n_p;
    assign lk.cs_low   = ~q.s2[1];
    assign lk.serial_in_pin      = q.s2[2];
    assign lk.wp_n     = q.s2[3];

endmodule

`default_nettype wire

// file: snv_guard.sv
`timescale 1ns/10ps
`default_nettype none

module snv_guard
    import snv_pkg::*;
(
    // status fields and protect pin
    input  wire logic [1:0]  i_bg,
    input  wire logic        i_lock,
    input  wire logic        i_wp_n,
    // target address
    input  wire logic [13:0] i_addr,
    // verdicts
    output logic             o_addr_locked,
    output logic             o_all_locked,
    output logic             o_status_locked
);

    assign o_addr_locked   = snv_guarded(i_bg, i_addr);
    assign o_all_locked    = |i_bg;
    assign o_status_locked = i_lock & ~i_wp_n;

endmodule

`default_nettype wire

// file: snv_top.sv
`timescale 1ns/10ps
`default_nettype none

`include "snv_regs.svh"

module snv_top
    import snv_pkg::*;
(
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    // serial link pins
    input  wire logic        I_SCK,
    input  wire logic        I_CS_N,
    input  wire logic        I_SERIAL_IN_PIN,
    input  wire logic        I_WP_N,
    output logic             O_SERIAL_OUT_PIN,
    output logic             O_SERIAL_OUT_OE,
    // array side
    input  wire logic [7:0]  I_NV_STATUS,
    input  wire logic [7:0]  I_ARR_RDATA,
    input  wire logic        I_ARR_DONE,
    output logic [15:0]      O_ARR_ADDR,
    output logic [7:0]       O_ARR_WDATA,
    output logic             O_ARR_WSTB,
    output logic             O_ARR_RREQ,
    output logic             O_ARR_START,
    output logic [2:0]       O_ARR_OP,
    // power state
    output logic             O_LOW_STANDBY,
    output logic             O_AUTO_SLEEP,
    output logic             O_POWER_DOWN,
    output logic             O_DEEP_SLEEP
);

    typedef struct packed {
        snv_phase_type phase;
        logic [7:0]    opc;
        logic [7:0]    in_sh;
        logic [2:0]    bit_cnt;
        logic [7:0]    byte_cnt;
        logic [15:0]   addr;
        logic [7:0]    out_sh;
        logic          ld_pend;
        logic          ld_stat;
        logic          serial_out_pin;
        logic          sdo_oe;
        logic [7:0]    sr;
        logic [7:0]    sw_data;
        logic [7:0]    wcnt;
        logic          flushing;
        logic [7:0]    flush_cnt;
        logic [6:0]    flush_idx;
        logic          pd;
        logic          deep;
        logic          init;
        logic [15:0]   arr_addr;
        logic [7:0]    arr_wdata;
        logic          wstb;
        logic          rreq;
        logic          start;
        snv_aop_type   arr_op;
        logic          low_stby;
        logic          auto_slp;
        logic          buf_we;
        logic [6:0]    buf_idx;
        logic [7:0]    buf_wdata;
    } snv_core_type;

    snv_core_type q;
    snv_core_type d;

    logic [7:0]  page_buf [128];
    logic        addr_locked;
    logic        all_locked;
    logic        status_locked;
    logic [7:0]  rx_byte;
    logic [7:0]  status_view;
    logic        wr_ok;
    logic        idle;

    snv_link_if lk ();

    snv_link_sync u_sync (
        .i_clk  (I_SYS_CLK),
        .i_rst  (I_RST),
        .i_sck  (I_SCK),
        .i_cs_n (I_CS_N),
        .i_sdi  (I_SERIAL_IN_PIN),
        .i_wp_n (I_WP_N),
        .lk     (lk)
    );

    snv_guard u_guard (
        .i_bg            (q.sr[`SNV_SR_GUARD_HI:`SNV_SR_GUARD_LO]),
        .i_lock          (q.sr[`SNV_SR_LOCK]),
        .i_wp_n          (lk.wp_n),
        .i_addr          (q.addr[13:0]),
        .o_addr_locked   (addr_locked),
        .o_all_locked    (all_locked),
        .o_status_locked (status_locked)
    );

    // page data held until the command is known complete
    always_ff @(posedge I_SYS_CLK)
    begin
        if (q.buf_we)
            page_buf[q.buf_idx] <= q.buf_wdata;
    end

    assign rx_byte     = {q.in_sh[6:0], lk.serial_in_pin};
    assign status_view = {q.sr[7:5], 1'b0, q.sr[3:0]};
    assign wr_ok       = q.sr[`SNV_SR_LATCH] & ~q.sr[`SNV_SR_BUSY];
    assign idle        = ~lk.cs_low & ~q.sr[`SNV_SR_BUSY] & ~q.pd & ~q.deep;

    always_comb
    begin
        d        = q;
        d.wstb   = 1'b0;
        d.rreq   = 1'b0;
        d.start  = 1'b0;
        d.buf_we = 1'b0;

        // nonvolatile fields come up from the cell image, volatile ones at zero
        if (!q.init)
        begin
            d.init = 1'b1;
            d.sr   = I_NV_STATUS & `SNV_SR_NV_MASK;
        end

        if (I_ARR_DONE)
            d.sr[`SNV_SR_BUSY] = 1'b0;

        // hand the page to the array one byte per cycle, then start it
        if (q.flushing)
        begin
            if (q.flush_cnt != 8'h00)
            begin
                d.wstb      = 1'b1;
                d.arr_addr  = {q.addr[15:7], q.flush_idx};
                d.arr_wdata = page_buf[q.flush_idx];
                d.flush_idx = q.flush_idx + 7'h01;
                d.flush_cnt = q.flush_cnt - 8'h01;
            end
            else
            begin
                d.flushing = 1'b0;
                d.start    = 1'b1;
                d.arr_op   = AOP_PROGRAM;
                d.arr_addr = q.addr;
            end
        end

        // reload the output shifter one cycle after a fetch
        if (q.ld_pend)
        begin
            d.ld_pend = 1'b0;
            d.out_sh  = q.ld_stat ? status_view : I_ARR_RDATA;
        end

        if (!lk.cs_low)
            d.sdo_oe = 1'b0;

        if (lk.cs_fall)
        begin
            d.bit_cnt  = 3'h0;
            d.byte_cnt = 8'h00;
            d.opc      = `SNV_OP_NONE;
            d.wcnt     = 8'h00;
            d.phase    = PH_OPC;
            if (q.deep)
            begin
                d.deep  = 1'b0;
                d.phase = PH_SKIP;
            end
        end
        else if (lk.sck_rise && lk.cs_low && q.phase != PH_IDLE)
        begin
            d.in_sh   = rx_byte;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == 3'h7)
            begin
                if (q.byte_cnt != 8'hFF)
                    d.byte_cnt = q.byte_cnt + 8'h01;
                unique case (q.phase)
                    PH_OPC:
                    begin
                        d.opc   = rx_byte;
                        d.phase = PH_SKIP;
                        if (q.pd && rx_byte != `SNV_OP_WAKE)
                            d.opc = `SNV_OP_NONE;
                        else
                        begin
                            unique case (rx_byte)
                                `SNV_OP_READ, `SNV_OP_FAST_FETCH,
                                `SNV_OP_PROGRAM, `SNV_OP_PAGE_ERASE:
                                    d.phase = PH_ADDR;
                                `SNV_OP_STATUS_FETCH:
                                begin
                                    d.phase   = PH_RDATA;
                                    d.ld_pend = 1'b1;
                                    d.ld_stat = 1'b1;
                                end
                                `SNV_OP_STATUS_STORE:
                                    d.phase = PH_WDATA;
                                default:
                                    d.phase = PH_SKIP;
                            endcase
                        end
                    end
                    PH_ADDR:
                    begin
                        d.addr = {q.addr[7:0], rx_byte};
                        if (q.byte_cnt == 8'h02)
                        begin
                            unique case (q.opc)
                                `SNV_OP_READ:
                                begin
                                    d.phase    = PH_RDATA;
                                    d.ld_pend  = 1'b1;
                                    d.ld_stat  = 1'b0;
                                    d.rreq     = 1'b1;
                                    d.arr_addr = {q.addr[7:0], rx_byte};
                                    d.addr     = {2'h0, {q.addr[5:0], rx_byte} + 14'h0001};
                                end
                                `SNV_OP_FAST_FETCH:
                                    d.phase = PH_DUMMY;
                                `SNV_OP_PROGRAM:
                                    d.phase = PH_WDATA;
                                default:
                                    d.phase = PH_SKIP;
                            endcase
                        end
                    end
                    PH_DUMMY:
                    begin
                        d.phase    = PH_RDATA;
                        d.ld_pend  = 1'b1;
                        d.ld_stat  = 1'b0;
                        d.rreq     = 1'b1;
                        d.arr_addr = q.addr;
                        d.addr     = {2'h0, q.addr[13:0] + 14'h0001};
                    end
                    PH_WDATA:
                    begin
                        if (q.opc == `SNV_OP_STATUS_STORE)
                            d.sw_data = rx_byte;
                        else
                        begin
                            d.buf_we    = 1'b1;
                            d.buf_idx   = q.addr[6:0] + q.wcnt[6:0];
                            d.buf_wdata = rx_byte;
                            if (q.wcnt != `SNV_PAGE_BYTES)
                                d.wcnt = q.wcnt + 8'h01;
                        end
                    end
                    PH_RDATA:
                    begin
                        d.ld_pend = 1'b1;
                        if (!q.ld_stat)
                        begin
                            d.rreq     = 1'b1;
                            d.arr_addr = q.addr;
                            d.addr     = {2'h0, q.addr[13:0] + 14'h0001};
                        end
                    end
                    PH_SKIP:
                        d.phase = PH_SKIP;
                    default:
                        d.phase = PH_IDLE;
                endcase
            end
        end
        else if (lk.sck_fall && lk.cs_low && q.phase == PH_RDATA)
        begin
            d.serial_out_pin    = q.out_sh[7];
            d.out_sh = {q.out_sh[6:0], 1'b0};
            d.sdo_oe = 1'b1;
        end

        // commands take effect only at a byte-aligned deselect
        if (lk.cs_rise && q.phase != PH_IDLE)
        begin
            d.phase = PH_IDLE;
            if (q.bit_cnt == 3'h0)
            begin
                unique case (q.opc)
                    `SNV_OP_LATCH_SET:
                        d.sr[`SNV_SR_LATCH] = 1'b1;
                    `SNV_OP_LATCH_CLEAR:
                        d.sr[`SNV_SR_LATCH] = 1'b0;
                    `SNV_OP_POWER_DOWN:
                    begin
                        d.pd                = 1'b1;
                        d.sr[`SNV_SR_LATCH] = 1'b0;
                    end
                    `SNV_OP_DEEP_SLEEP:
                        d.deep = 1'b1;
                    `SNV_OP_WAKE:
                        d.pd = 1'b0;
                    `SNV_OP_PROGRAM:
                    begin
                        if (q.byte_cnt >= `SNV_MIN_PROGRAM && wr_ok && !addr_locked)
                        begin
                            d.flushing          = 1'b1;
                            d.flush_cnt         = q.wcnt;
                            d.flush_idx         = q.addr[6:0];
                            d.sr[`SNV_SR_BUSY]  = 1'b1;
                            d.sr[`SNV_SR_LATCH] = 1'b0;
                        end
                    end
                    `SNV_OP_PAGE_ERASE:
                    begin
                        if (q.byte_cnt >= `SNV_MIN_ERASE && wr_ok && !addr_locked)
                        begin
                            d.start             = 1'b1;
                            d.arr_op            = AOP_PAGE_ERASE;
                            d.arr_addr          = q.addr;
                            d.sr[`SNV_SR_BUSY]  = 1'b1;
                            d.sr[`SNV_SR_LATCH] = 1'b0;
                        end
                    end
                    `SNV_OP_CHIP_ERASE_A, `SNV_OP_CHIP_ERASE_B:
                    begin
                        if (wr_ok && !all_locked)
                        begin
                            d.start             = 1'b1;
                            d.arr_op            = AOP_CHIP_ERASE;
                            d.arr_addr          = 16'h0000;
                            d.sr[`SNV_SR_BUSY]  = 1'b1;
                            d.sr[`SNV_SR_LATCH] = 1'b0;
                        end
                    end
                    `SNV_OP_STATUS_STORE:
                    begin
                        if (q.byte_cnt >= `SNV_MIN_STORE && wr_ok && !status_locked)
                        begin
                            d.sr = (q.sw_data & `SNV_SR_NV_MASK)
                                 | (q.sr & ~`SNV_SR_NV_MASK);
                            d.sr[`SNV_SR_BUSY] = 1'b1;
                            d.start            = 1'b1;
                            d.arr_op           = AOP_STATUS;
                            d.arr_wdata        = q.sw_data & `SNV_SR_NV_MASK;
                        end
                    end
                    default:
                        d.phase = PH_IDLE;
                endcase
            end
        end

        d.low_stby = idle & q.sr[`SNV_SR_LOW_STBY] & ~q.sr[`SNV_SR_AUTO_SLP];
        d.auto_slp = idle & q.sr[`SNV_SR_AUTO_SLP];
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            q          <= '0;
            q.phase    <= PH_IDLE;
            q.arr_op   <= AOP_NONE;
            q.sr       <= `SNV_SR_RESET;
        end
        else
            q <= d;
    end

    assign O_SERIAL_OUT_PIN = q.serial_out_pin;
    assign O_SERIAL_OUT_OE  = q.sdo_oe;
    assign O_ARR_ADDR       = q.arr_addr;
    assign O_ARR_WDATA      = q.arr_wdata;
    assign O_ARR_WSTB       = q.wstb;
    assign O_ARR_RREQ       = q.rreq;
    assign O_ARR_START      = q.start;
    assign O_ARR_OP         = q.arr_op;
    assign O_LOW_STANDBY    = q.low_stby;
    assign O_AUTO_SLEEP     = q.auto_slp;
    assign O_POWER_DOWN     = q.pd;
    assign O_DEEP_SLEEP     = q.deep;

endmodule

`default_nettype wire

// file: snv_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module snv_top_asserts (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    // watched pins
    input wire logic I_SCK,
    input wire logic I_CS_N,
    input wire logic O_SERIAL_OUT_PIN,
    input wire logic O_SERIAL_OUT_OE,
    input wire logic O_ARR_WSTB,
    input wire logic O_ARR_START,
    input wire logic O_LOW_STANDBY,
    input wire logic O_AUTO_SLEEP,
    input wire logic O_POWER_DOWN
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    property p_oe_off; I_CS_N [*5] |-> !O_SERIAL_OUT_OE; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe while deselected");
    property p_sdo_fall; O_SERIAL_OUT_OE && $changed(O_SERIAL_OUT_PIN) |-> !$past(I_SCK, 3);
    endproperty
    a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved off fall");
    property p_oe_rise; $rose(O_SERIAL_OUT_OE) |-> !$past(I_SCK, 3) && !$past(I_CS_N, 3);
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("oe rose off fall");
    property p_start_cs; O_ARR_START |-> $past(I_CS_N, 2); endproperty
    a_start_cs: assert property (p_start_cs) else $error("start before select rise");
    property p_wstb_cs; O_ARR_WSTB |-> $past(I_CS_N, 2); endproperty
    a_wstb_cs: assert property (p_wstb_cs) else $error("byte before select rise");
    property p_start_one; O_ARR_START |=> !O_ARR_START [*8]; endproperty
    a_start_one: assert property (p_start_one) else $error("start repeated");
    property p_idle; $rose(O_LOW_STANDBY) || $rose(O_AUTO_SLEEP) |-> $past(I_CS_N, 2);
    endproperty
    a_idle: assert property (p_idle) else $error("standby while selected");
    property p_excl; O_LOW_STANDBY |-> !O_AUTO_SLEEP && !O_POWER_DOWN; endproperty
    a_excl: assert property (p_excl) else $error("two power states");
endmodule
bind snv_top snv_top_asserts u_chk (.I_SYS_CLK, .I_RST, .I_SCK, .I_CS_N, .O_SERIAL_OUT_PIN,
    .O_SERIAL_OUT_OE, .O_ARR_WSTB, .O_ARR_START, .O_LOW_STANDBY, .O_AUTO_SLEEP, .O_POWER_DOWN);
`default_nettype wire

// file: snv_spi_master.sv
`timescale 1ns/10ps
`default_nettype none
module snv_spi_master (
    // timing
    input  wire logic i_clk,
    input  wire logic i_mode3,
    // link pins
    input  wire logic i_sdo,
    output logic      o_sck = 1'b0,
    output logic      o_cs_n = 1'b1,
    output logic      o_sdi = 1'b0
);
    task automatic gap(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic sel();
        o_sck <= i_mode3;
        gap(4);
        o_cs_n <= 1'b0;
        gap(4);
    endtask
    task automatic desel();
        o_sck <= i_mode3;
        gap(4);
        o_cs_n <= 1'b1;
        o_sdi <= ~o_sdi;
        gap(8);
    endtask
    // msb first, bit set while clock low
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_sck <= 1'b0;
            o_sdi <= tx[i];
            gap(4);
            o_sck <= 1'b1;
            gap(4);
            rx = {rx[6:0], i_sdo};
        end
    endtask
endmodule
`default_nettype wire

// file: spi_nvm_command_protect_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spi_nvm_command_protect_tb;
    logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, done = 1'b0, mode3 = 1'b0;
    logic sck, cs_n, serial_in_pin, so, oe, wstb, rreq, start, lsb, asl, pdn, dsl;
    logic [7:0] wd, wdata, rd0, rd;
    logic [15:0] addr;
    wire [7:0] rdat = rreq ? (addr[7:0] ^ 8'h5A) : 8'h00;
    logic [2:0] op, lop;
    int err_count = 0, check_count = 0, ns = 0, n0;
    wire sdo_w = oe ? so : ~so;
    always #12.5 clk = ~clk;
    snv_top dut (.I_SYS_CLK(clk), .I_RST(rst), .I_SCK(sck), .I_CS_N(cs_n),
        .I_SERIAL_IN_PIN(serial_in_pin), .I_WP_N(wp_n), .O_SERIAL_OUT_PIN(so), .O_SERIAL_OUT_OE(oe),
        .I_NV_STATUS(8'h00), .I_ARR_RDATA(rdat), .I_ARR_DONE(done), .O_ARR_ADDR(addr),
        .O_ARR_WDATA(wdata), .O_ARR_WSTB(wstb), .O_ARR_RREQ(rreq), .O_ARR_START(start),
        .O_ARR_OP(op), .O_LOW_STANDBY(lsb), .O_AUTO_SLEEP(asl), .O_POWER_DOWN(pdn),
        .O_DEEP_SLEEP(dsl));
    snv_spi_master m (.i_clk(clk), .i_mode3(mode3), .i_sdo(sdo_w), .o_sck(sck),
        .o_cs_n(cs_n), .o_sdi(serial_in_pin));
    // array stand-in
    always @(posedge clk)
    begin
        if (wstb) wd <= wdata ^ addr[7:0];
        if (start)
        begin
            ns <= ns + 1;
            lop <= op;
        end
    end
    task automatic give_verdict();
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [7:0] q[$], input int nrd);
        m.sel();
        foreach (q[i]) m.xfer(q[i], rd);
        for (int i = 0; i < nrd; i++)
        begin
            m.xfer(8'hFF, rd);
            if (i == 0) rd0 = rd;
        end
        m.desel();
    endtask
    task automatic stat(input logic [7:0] msk, input logic [7:0] exp);
        run({8'h05}, 1);
        chk(rd & msk, exp);
    endtask
    task automatic fin();
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        run({8'h05}, 2);
        chk(rd0 | rd, 8'h00);
        run({8'h01, 8'h8C}, 0);
        stat(8'hFF, 8'h00);
        run({8'h06}, 0);
        stat(8'hFF, 8'h02);
        run({8'h04}, 0);
        stat(8'hFF, 8'h00);
        run({8'h06}, 0);
        run({8'h01, 8'hBC}, 0);
        stat(8'hFD, 8'hAD);
        fin();
        stat(8'hFD, 8'hAC);
        chk(lsb, 8'h01);
        wp_n <= 1'b0;
        run({8'h06}, 0);
        run({8'h01, 8'h00}, 0);
        stat(8'hFD, 8'hAC);
        wp_n <= 1'b1;
        run({8'h06}, 0);
        run({8'h01, 8'h40}, 0);
        fin();
        stat(8'hFD, 8'h40);
        chk({lsb, asl}, 8'h01);
        run({8'h03, 8'h3F, 8'hFF}, 2);
        chk({rd0, rd} == 16'hA55A, 8'h01);
        run({8'h0B, 8'h00, 8'h10, 8'h00}, 2);
        chk({rd0, rd} == 16'h4A4B, 8'h01);
        run({8'h06}, 0);
        n0 = ns;
        run({8'h02, 8'h00, 8'h10, 8'hAA}, 0);
        chk({lop, wd} == 11'h1BA, 8'h01);
        stat(8'hFF, 8'h41);
        run({8'h06}, 0);
        run({8'h42, 8'h00, 8'h00}, 0);
        chk(8'(ns - n0), 8'h01);
        fin();
        run({8'h42, 8'h00}, 0);
        stat(8'hFF, 8'h42);
        run({8'h42, 8'h00, 8'h00}, 0);
        chk(lop, 8'h02);
        fin();
        stat(8'hFF, 8'h40);
        run({8'h06}, 0);
        run({8'h01, 8'h44}, 0);
        fin();
        n0 = ns;
        run({8'h06}, 0);
        run({8'h02, 8'h30, 8'h00, 8'h11}, 0);
        run({8'h06}, 0);
        run({8'h02, 8'h2F, 8'hFF, 8'h11}, 0);
        chk(8'(ns - n0), 8'h01);
        fin();
        mode3 <= 1'b1;
        @(posedge clk);
        stat(8'hFF, 8'h44);
        run({8'h06}, 0);
        run({8'hC7}, 0);
        stat(8'hFF, 8'h46);
        run({8'hB9}, 0);
        chk(pdn, 8'h01);
        run({8'hAB}, 0);
        chk(pdn, 8'h00);
        run({8'h79}, 0);
        chk(dsl, 8'h01);
        run({8'h05}, 0);
        chk(dsl, 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
